// >>> cio_pkg.sv
package cio_pkg;

    // Geometry
    localparam int NPORT = 7;
    localparam int PW = 8;
    localparam int NPIN = NPORT * PW;

    // Port indices
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;
    localparam int PORT_G = 6;

    // Address layout: bit 7 clear selects a port block, [6:4] port, [3:0] register
    localparam int ADDR_PORT_LSB = 4;
    localparam int ADDR_BLOCK_BIT = 7;
    localparam logic [3:0] REG_FUNC = 4'h0;
    localparam logic [3:0] REG_DIR = 4'h1;
    localparam logic [3:0] REG_DRIVE = 4'h2;
    localparam logic [3:0] REG_DIN = 4'h3;
    localparam logic [3:0] REG_DOUT = 4'h4;
    localparam logic [3:0] REG_OCELL = 4'h5;
    localparam logic [3:0] REG_OMASK = 4'h6;
    localparam logic [3:0] REG_ICELL = 4'h7;
    localparam logic [3:0] REG_OEN = 4'h8;
    localparam logic [7:0] ADDR_MEMMAP_CFG = 8'h80;
    localparam int PERIPH_BUF_BIT = 7;

    // Reset values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] DOUT_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] MEMMAP_RESET = 8'h00;

    // Per-port feature sets, bit n is port n (A = bit 0)
    localparam logic [6:0] HAS_FUNC = 7'h70;
    localparam logic [6:0] HAS_OE_TERM = 7'h27;
    localparam logic [6:0] HAS_OCELL = 7'h03;
    localparam logic [6:0] HAS_ICELL = 7'h07;
    localparam logic [6:0] HAS_OPEN_DRAIN = 7'h5B;
    localparam logic [6:0] HAS_SLEW = 7'h24;

    // Pin population and port E programming pins
    localparam logic [7:0] FULL_MASK = 8'hFF;
    localparam logic [7:0] PORT_D_MASK = 8'h0F;
    localparam logic [7:0] JTAG_PIN_MASK = 8'h0F;
    localparam logic [7:0] JTAG_TDO_MASK = 8'h08;

    // Host-visible configuration of one port
    typedef struct packed {
        logic [7:0] func;
        logic [7:0] dir;
        logic [7:0] drive;
        logic [7:0] dout;
    } cio_cfg_t;

    // Registered pad controls of one port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] fast;
    } cio_pad_t;

    // Alternate owner of a port's pads
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] oe;
        logic [7:0] data;
    } cio_ovr_t;

endpackage : cio_pkg

// >>> cio_pin_stage.sv
`timescale 1ns/1ps
module cio_pin_stage #(
    parameter bit HAS_FUNC = 1'b0,
    parameter bit HAS_OE_TERM = 1'b0,
    parameter bit OPEN_DRAIN = 1'b0,
    parameter bit SLEW = 1'b0,
    parameter logic [7:0] PIN_MASK = 8'hFF
) (
    input wire logic clk,
    input wire logic resetn,
    input wire cio_pkg::cio_cfg_t cfg,
    input wire logic [7:0] array_oe,
    input wire logic [7:0] array_data,
    input wire logic [7:0] addr_byte,
    input wire cio_pkg::cio_ovr_t ovr,
    output cio_pkg::cio_pad_t pad,
    output logic [7:0] oe_state
);

    wire [7:0] oe_term;
    wire [7:0] addr_mode;
    wire [7:0] gp_en;
    wire [7:0] en;
    wire [7:0] data;
    wire [7:0] od_sel;
    cio_pkg::cio_pad_t next_pad;

    // Each bit works on its own pin only
    assign oe_term = HAS_OE_TERM ? array_oe : 8'h00;
    assign addr_mode = HAS_FUNC ? (cfg.func & cfg.dir) : 8'h00;
    assign gp_en = (cfg.dir | oe_term) & PIN_MASK;
    assign data = (ovr.en & ovr.data)
                | (~ovr.en & addr_mode & addr_byte)
                | (~ovr.en & ~addr_mode & oe_term & array_data)
                | (~ovr.en & ~addr_mode & ~oe_term & cfg.dout);
    assign en = ((ovr.en & ovr.oe) | (~ovr.en & gp_en)) & PIN_MASK;

    // Open drain only pulls low; pull-ups are external
    assign od_sel = OPEN_DRAIN ? (cfg.drive & PIN_MASK & ~ovr.en) : 8'h00;
    assign next_pad.oe = en & ~(od_sel & data);
    assign next_pad.out = data & ~od_sel;
    assign next_pad.fast = SLEW ? (cfg.drive & PIN_MASK) : 8'h00; // follows the bit, driving or not
    assign oe_state = en;

    // Pads registered so the pins never see decode glitches
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pad <= '0;
        end else begin
            pad <= next_pad;
        end
    end

endmodule : cio_pin_stage

// >>> cio_port_bank.sv
`timescale 1ns/1ps
module cio_port_bank (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic IO_SEL,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [7:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA,
    output logic IO_RVALID,
    input wire logic [55:0] PIN_IN,
    output logic [55:0] PIN_OUT,
    output logic [55:0] PIN_OE,
    output logic [55:0] PIN_FAST,
    input wire logic ADDRESS_STROBE_INPUT,
    input wire logic [15:0] LATCHED_ADDR,
    input wire logic ADDR_OUT_HIGH_G,
    input wire logic [55:0] ARRAY_OE,
    input wire logic [55:0] ARRAY_DATA,
    input wire logic [15:0] CELL_LOAD,
    input wire logic [15:0] CELL_D,
    input wire logic [23:0] INPUT_CELL_LATCH,
    input wire logic [55:0] DECODE_USE,
    output logic [55:0] ARRAY_IN,
    output logic [55:0] DECODE_ADDR_IN,
    output logic [15:0] OUTPUT_CELL,
    input wire logic DATA_PORT_MODE,
    input wire logic BUS_READ,
    input wire logic BUS_WRITE,
    input wire logic [7:0] BUS_RDATA,
    input wire logic [7:0] BUS_WDATA,
    input wire logic PERIPH_SELECT_ZERO,
    input wire logic PERIPH_SELECT_ONE,
    output logic [7:0] PORT_F_DATA,
    input wire logic JTAG_EN,
    input wire logic JTAG_TDO,
    input wire logic JTAG_TDO_OE
);

    // Register read decode, shared by the read mux
    function automatic logic reg_exists(input logic [2:0] port, input logic [3:0] idx);
        logic hit;
        hit = 1'b0;
        if (port < 3'(cio_pkg::NPORT)) begin
            unique case (idx)
                cio_pkg::REG_FUNC: hit = cio_pkg::HAS_FUNC[port];
                cio_pkg::REG_DIR, cio_pkg::REG_DRIVE, cio_pkg::REG_DIN, cio_pkg::REG_DOUT: hit = 1'b1;
                cio_pkg::REG_OCELL, cio_pkg::REG_OMASK: hit = cio_pkg::HAS_OCELL[port];
                cio_pkg::REG_ICELL: hit = cio_pkg::HAS_ICELL[port];
                cio_pkg::REG_OEN: hit = cio_pkg::HAS_OE_TERM[port];
                default: hit = 1'b0;
            endcase
        end
        return hit;
    endfunction : reg_exists

    // Host write strobes; read-only targets simply have no write enable
    wire host_wr = IO_SEL & IO_WR;
    wire host_rd = IO_SEL & IO_RD;
    wire in_block = ~IO_ADDR[cio_pkg::ADDR_BLOCK_BIT];
    wire [2:0] sel_port = IO_ADDR[6:4];
    wire [3:0] sel_reg = IO_ADDR[3:0];
    wire memmap_wr = host_wr & (IO_ADDR == cio_pkg::ADDR_MEMMAP_CFG);

    // Pins and strobe come from outside: two flops before any use
    logic [55:0] pin_meta;
    logic [55:0] pin_sync;
    logic strobe_meta;
    logic strobe_sync;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_meta <= '0;
            pin_sync <= '0;
            strobe_meta <= 1'b0;
            strobe_sync <= 1'b0;
        end else begin
            pin_meta <= PIN_IN;
            pin_sync <= pin_meta;
            strobe_meta <= ADDRESS_STROBE_INPUT;
            strobe_sync <= strobe_meta;
        end
    end

    // Memory-map config; only its peripheral buffer bit steers this block
    logic [7:0] memmap_cfg;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            memmap_cfg <= cio_pkg::MEMMAP_RESET;
        end else if (memmap_wr) begin
            memmap_cfg <= IO_WDATA;
        end
    end

    wire periph_buf = memmap_cfg[cio_pkg::PERIPH_BUF_BIT];

    // Input cells on A,B,C: transparent while strobe high, hold after
    logic [23:0] input_cell;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            input_cell <= '0;
        end else if (strobe_sync) begin
            input_cell <= pin_sync[23:0];
        end
    end

    // Array inputs: A,B,C via cell or direct, D,E,F,G direct
    wire [23:0] abc_in = (INPUT_CELL_LATCH & input_cell) | (~INPUT_CELL_LATCH & pin_sync[23:0]);
    wire [55:0] next_array_in = {pin_sync[55:24], abc_in};

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ARRAY_IN <= '0;
            DECODE_ADDR_IN <= '0;
            PORT_F_DATA <= '0;
        end else begin
            ARRAY_IN <= next_array_in;
            DECODE_ADDR_IN <= next_array_in & DECODE_USE;
            PORT_F_DATA <= pin_sync[cio_pkg::PORT_F * 8 +: 8];
        end
    end

    // Address byte for address-out pins; G may carry the high byte
    wire [7:0] addr_low = LATCHED_ADDR[7:0];
    wire [7:0] addr_g = ADDR_OUT_HIGH_G ? LATCHED_ADDR[15:8] : LATCHED_ADDR[7:0];

    // Port F ownership: data port wins over peripheral buffer
    wire periph_drive = periph_buf & (PERIPH_SELECT_ZERO | PERIPH_SELECT_ONE) & BUS_WRITE;
    cio_pkg::cio_ovr_t ovr_f;
    assign ovr_f.en = (DATA_PORT_MODE | periph_buf) ? 8'hFF : 8'h00;
    assign ovr_f.oe = DATA_PORT_MODE ? {8{BUS_READ}} : {8{periph_drive}};
    assign ovr_f.data = DATA_PORT_MODE ? BUS_RDATA : BUS_WDATA;

    // Port E programming pins; only the data-out pin is ever driven
    cio_pkg::cio_ovr_t ovr_e;
    assign ovr_e.en = JTAG_EN ? cio_pkg::JTAG_PIN_MASK : 8'h00;
    assign ovr_e.oe = {8{JTAG_TDO_OE}} & cio_pkg::JTAG_TDO_MASK;
    assign ovr_e.data = {8{JTAG_TDO}} & cio_pkg::JTAG_TDO_MASK;

    logic [7:0] port_rd [cio_pkg::NPORT];
    logic [7:0] ocell_w [2];

    genvar p;
    generate
        for (p = 0; p < cio_pkg::NPORT; p++) begin : g_port
            localparam logic [7:0] PMASK = (p == cio_pkg::PORT_D) ? cio_pkg::PORT_D_MASK : cio_pkg::FULL_MASK;
            wire wr_here = host_wr & in_block & (sel_port == 3'(p));
            cio_pkg::cio_cfg_t cfg;
            cio_pkg::cio_ovr_t ovr;
            cio_pkg::cio_pad_t pad;
            logic [7:0] omask;
            logic [7:0] ocell;
            logic [7:0] oe_state;
            wire [7:0] arr_data;
            wire [7:0] din = pin_sync[p * 8 +: 8] & PMASK;

            // Configuration registers, cleared at reset, read back
            always_ff @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    cfg.func <= cio_pkg::CFG_RESET;
                    cfg.dir <= cio_pkg::CFG_RESET;
                    cfg.drive <= cio_pkg::CFG_RESET;
                    cfg.dout <= cio_pkg::DOUT_RESET;
                end else if (wr_here) begin
                    if (sel_reg == cio_pkg::REG_FUNC && cio_pkg::HAS_FUNC[p]) begin
                        cfg.func <= IO_WDATA;
                    end
                    if (sel_reg == cio_pkg::REG_DIR) begin
                        cfg.dir <= IO_WDATA & PMASK;
                    end
                    if (sel_reg == cio_pkg::REG_DRIVE) begin
                        cfg.drive <= IO_WDATA & PMASK;
                    end
                    if (sel_reg == cio_pkg::REG_DOUT) begin
                        cfg.dout <= IO_WDATA;
                    end
                end
            end

            if (cio_pkg::HAS_OCELL[p]) begin : g_ocell
                // Host load beats an array load in the same cycle
                wire host_load = wr_here & (sel_reg == cio_pkg::REG_OCELL);
                wire [7:0] load_bits = host_load ? ~omask : 8'h00;
                wire [7:0] arr_bits = CELL_LOAD[p * 8 +: 8] & ~load_bits;
                always_ff @(posedge CLK or negedge RESETN) begin
                    if (!RESETN) begin
                        omask <= cio_pkg::MASK_RESET;
                        ocell <= '0;
                    end else begin
                        if (wr_here && sel_reg == cio_pkg::REG_OMASK) begin
                            omask <= IO_WDATA;
                        end
                        ocell <= (load_bits & IO_WDATA) | (arr_bits & CELL_D[p * 8 +: 8])
                               | (~load_bits & ~arr_bits & ocell);
                    end
                end
                assign arr_data = ocell;
            end else begin : g_no_ocell
                assign omask = 8'h00;
                assign ocell = 8'h00;
                assign arr_data = ARRAY_DATA[p * 8 +: 8];
            end

            if (p == cio_pkg::PORT_F) begin : g_ovr_f
                assign ovr = ovr_f;
            end else if (p == cio_pkg::PORT_E) begin : g_ovr_e
                assign ovr = ovr_e;
            end else begin : g_ovr_none
                assign ovr = '0;
            end

            cio_pin_stage #(
                .HAS_FUNC(cio_pkg::HAS_FUNC[p]),
                .HAS_OE_TERM(cio_pkg::HAS_OE_TERM[p]),
                .OPEN_DRAIN(cio_pkg::HAS_OPEN_DRAIN[p]),
                .SLEW(cio_pkg::HAS_SLEW[p]),
                .PIN_MASK(PMASK)
            ) u_stage (
                .clk(CLK),
                .resetn(RESETN),
                .cfg(cfg),
                .array_oe(ARRAY_OE[p * 8 +: 8]),
                .array_data(arr_data),
                .addr_byte((p == cio_pkg::PORT_G) ? addr_g : addr_low),
                .ovr(ovr),
                .pad(pad),
                .oe_state(oe_state)
            );

            assign PIN_OUT[p * 8 +: 8] = pad.out;
            assign PIN_OE[p * 8 +: 8] = pad.oe;
            assign PIN_FAST[p * 8 +: 8] = pad.fast;

            // Read mux per port; absent registers fall out through reg_exists
            assign port_rd[p] =
                (sel_reg == cio_pkg::REG_FUNC) ? cfg.func :
                (sel_reg == cio_pkg::REG_DIR) ? cfg.dir :
                (sel_reg == cio_pkg::REG_DRIVE) ? cfg.drive :
                (sel_reg == cio_pkg::REG_DIN) ? din :
                (sel_reg == cio_pkg::REG_DOUT) ? cfg.dout :
                (sel_reg == cio_pkg::REG_OCELL) ? ocell :
                (sel_reg == cio_pkg::REG_OMASK) ? omask :
                (sel_reg == cio_pkg::REG_ICELL) ? (cio_pkg::HAS_ICELL[p] ? input_cell[(p % 3) * 8 +: 8] : 8'h00) :
                (sel_reg == cio_pkg::REG_OEN) ? oe_state : 8'h00;

            if (p < 2) begin : g_ocell_out
                assign ocell_w[p] = ocell;
            end
        end
    endgenerate

    // Read data: unmapped addresses return zero, nothing changes state
    wire [7:0] next_rdata =
        (IO_ADDR == cio_pkg::ADDR_MEMMAP_CFG) ? memmap_cfg :
        (in_block && reg_exists(sel_port, sel_reg)) ? port_rd[sel_port] : 8'h00;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            IO_RDATA <= '0;
            IO_RVALID <= 1'b0;
            OUTPUT_CELL <= '0;
        end else begin
            IO_RVALID <= host_rd;
            if (host_rd) begin
                IO_RDATA <= next_rdata;
            end
            OUTPUT_CELL <= {ocell_w[1], ocell_w[0]};
        end
    end

endmodule : cio_port_bank

// >>> cio_port_bank_props.sv
`timescale 1ns/1ps
// Port-level relations of the port bank, one clock domain
module cio_port_bank_props (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic IO_SEL,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [7:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    input wire logic [7:0] IO_RDATA,
    input wire logic IO_RVALID,
    input wire logic [55:0] PIN_OUT,
    input wire logic [55:0] PIN_OE,
    input wire logic [55:0] PIN_FAST,
    input wire logic [55:0] DECODE_USE,
    input wire logic [55:0] DECODE_ADDR_IN,
    input wire logic DATA_PORT_MODE,
    input wire logic BUS_READ,
    input wire logic [7:0] BUS_RDATA,
    input wire logic JTAG_EN,
    input wire logic JTAG_TDO_OE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    // Write then read of port A direction, back to back
    sequence s_wr_dir_a;
        IO_SEL && IO_WR && !IO_RD && IO_ADDR == 8'h01;
    endsequence
    sequence s_rd_dir_a;
        IO_SEL && IO_RD && !IO_WR && IO_ADDR == 8'h01;
    endsequence
    AST_DIR_ECHO: assert property (s_wr_dir_a ##1 s_rd_dir_a |=> IO_RDATA == $past(IO_WDATA, 2))
        else $error("direction readback differs from written value");
    AST_RVALID: assert property (IO_SEL && IO_RD |=> IO_RVALID)
        else $error("read not answered");
    AST_QUIET: assert property (!(IO_SEL && IO_RD) |=> !IO_RVALID && $stable(IO_RDATA))
        else $error("read data moved without a read");
    AST_PORTD_HIGH: assert property (PIN_OE[31:28] == 4'h0)
        else $error("absent port D pin driven");
    AST_FAST_CF: assert property ({PIN_FAST[55:48], PIN_FAST[39:24], PIN_FAST[15:0]} == 40'h0)
        else $error("fast edge on a port without edge-rate control");
    AST_DECODE: assert property (DECODE_USE == 56'h0 && $past(DECODE_USE) == 56'h0 |-> DECODE_ADDR_IN == 56'h0)
        else $error("decode address input without decode use");
    AST_JTAG_OFF: assert property (JTAG_EN && !JTAG_TDO_OE |=> !PIN_OE[35])
        else $error("programming data pin driven while disabled");
    AST_DATA_RD: assert property (DATA_PORT_MODE && BUS_READ |=> PIN_OE[47:40] == 8'hFF && PIN_OUT[47:40] == $past(BUS_RDATA))
        else $error("data port not driving read data");
    AST_DATA_IDLE: assert property (DATA_PORT_MODE && !BUS_READ |=> PIN_OE[47:40] == 8'h00)
        else $error("data port driving outside a read");
endmodule : cio_port_bank_props

// >>> cio_pad_model.sv
`timescale 1ns/1ps
// Board side of the pads: another driver where enabled, else pull-up
module cio_pad_model (
    input wire logic [55:0] pin_out,
    input wire logic [55:0] pin_oe,
    input wire logic [55:0] ext_en,
    input wire logic [55:0] ext_val,
    output logic [55:0] pin_in
);
    // Released lines with no board driver go high, open-drain pins rely on it
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule : cio_pad_model

// >>> cio_port_bank_bench.sv
`timescale 1ns/1ps
module cio_port_bank_bench;
    logic clk, resetn, sel, wr, rd, rvalid, strobe, hi_g, dpm, bus_rd, bus_wr, ps0, ps1, jtag_en;
    logic [7:0] addr, wdata, rdata, bus_rdata, bus_wdata, pf_data;
    logic [15:0] laddr, ocell_out;
    logic [23:0] icl;
    logic [55:0] pin_in, pin_out, pin_oe, pin_fast, aoe, duse, ext_en, ext_val, arr_in, dec_in;
    int n_fail, checks, cyc;
    cio_port_bank dut (.CLK(clk), .RESETN(resetn), .IO_SEL(sel), .IO_WR(wr), .IO_RD(rd), .IO_ADDR(addr),
        .IO_WDATA(wdata), .IO_RDATA(rdata), .IO_RVALID(rvalid), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .PIN_FAST(pin_fast), .ADDRESS_STROBE_INPUT(strobe), .LATCHED_ADDR(laddr),
        .ADDR_OUT_HIGH_G(hi_g), .ARRAY_OE(aoe), .ARRAY_DATA(56'h0), .CELL_LOAD(16'h0), .CELL_D(16'h0),
        .INPUT_CELL_LATCH(icl), .DECODE_USE(duse), .ARRAY_IN(arr_in), .DECODE_ADDR_IN(dec_in),
        .OUTPUT_CELL(ocell_out),
        .DATA_PORT_MODE(dpm), .BUS_READ(bus_rd), .BUS_WRITE(bus_wr), .BUS_RDATA(bus_rdata),
        .BUS_WDATA(bus_wdata), .PERIPH_SELECT_ZERO(ps0), .PERIPH_SELECT_ONE(ps1), .PORT_F_DATA(pf_data),
        .JTAG_EN(jtag_en), .JTAG_TDO(1'b0), .JTAG_TDO_OE(1'b0));
    cio_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            results();
        end
    end
    function automatic logic [7:0] ra(input int p, input logic [3:0] r);
        return {1'b0, p[2:0], r};
    endfunction : ra
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk56(input logic [55:0] got, input logic [55:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk56
    // Bus requests held over one sampling edge; the next call changes them
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        sel = 1'b1;
        wr = 1'b1;
        rd = 1'b0;
        addr = a;
        wdata = d;
        @(posedge clk) #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        sel = 1'b1;
        wr = 1'b0;
        rd = 1'b1;
        addr = a;
        @(posedge clk) #1;
        chk8((rvalid === 1'b1) ? rdata : ~exp, exp);
    endtask : rd_reg
    task automatic idle(input int n);
        sel = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    task automatic results();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    initial begin
        {resetn, sel, wr, rd, strobe, hi_g, dpm, bus_rd, bus_wr, ps0, ps1, jtag_en} = '0;
        {addr, wdata, bus_rdata, bus_wdata, laddr, icl} = '0;
        {aoe, duse, ext_en, ext_val} = '0;
        repeat (4) @(posedge clk);
        #1;
        resetn = 1'b1;
        // Reset values, readback and unused bits on every port
        for (int p = 0; p < 7; p++) begin
            rd_reg(ra(p, cio_pkg::REG_DIR), 8'h00);
            rd_reg(ra(p, cio_pkg::REG_DRIVE), 8'h00);
            rd_reg(ra(p, cio_pkg::REG_FUNC), 8'h00);
            wr_reg(ra(p, cio_pkg::REG_DIR), 8'hA5);
            rd_reg(ra(p, cio_pkg::REG_DIR), p == 3 ? 8'h05 : 8'hA5);
            wr_reg(ra(p, cio_pkg::REG_DRIVE), 8'h5A);
            rd_reg(ra(p, cio_pkg::REG_DRIVE), p == 3 ? 8'h0A : 8'h5A);
            wr_reg(ra(p, cio_pkg::REG_FUNC), 8'hC3);
            rd_reg(ra(p, cio_pkg::REG_FUNC), p > 3 ? 8'hC3 : 8'h00);
            wr_reg(ra(p, cio_pkg::REG_FUNC), 8'h00);
            wr_reg(ra(p, cio_pkg::REG_DIR), 8'h00);
            wr_reg(ra(p, cio_pkg::REG_DRIVE), 8'h00);
        end
        // Read-only, absent and unmapped places
        wr_reg(ra(0, cio_pkg::REG_OEN), 8'hFF);
        rd_reg(ra(0, cio_pkg::REG_OEN), 8'h00);
        rd_reg(8'h7F, 8'h00);
        rd_reg(ra(3, cio_pkg::REG_OMASK), 8'h00);
        // Port G output, then open drain with pull-up
        wr_reg(ra(6, cio_pkg::REG_DOUT), 8'h3C);
        wr_reg(ra(6, cio_pkg::REG_DIR), 8'h0F);
        idle(4);
        chk56(pin_oe, {8'h0F, 48'h0});
        chk56(pin_out & pin_oe, {8'h0C, 48'h0});
        rd_reg(ra(6, cio_pkg::REG_DOUT), 8'h3C);
        rd_reg(ra(6, cio_pkg::REG_DIN), 8'hFC);
        wr_reg(ra(6, cio_pkg::REG_DRIVE), 8'hFF);
        idle(4);
        chk56(pin_oe, {8'h03, 48'h0});
        rd_reg(ra(6, cio_pkg::REG_DIN), 8'hFC);
        // Latched address out on port G, both halves
        wr_reg(ra(6, cio_pkg::REG_DRIVE), 8'h00);
        laddr = 16'hA55A;
        hi_g = 1'b1;
        wr_reg(ra(6, cio_pkg::REG_FUNC), 8'hFF);
        wr_reg(ra(6, cio_pkg::REG_DIR), 8'hFF);
        idle(3);
        chk56(pin_out, {8'hA5, 48'h0});
        hi_g = 1'b0;
        idle(2);
        chk56(pin_out, {8'h5A, 48'h0});
        wr_reg(ra(6, cio_pkg::REG_FUNC), 8'h00);
        wr_reg(ra(6, cio_pkg::REG_DIR), 8'h00);
        // Edge rate on C only; open drain bits on A give no fast edge
        wr_reg(ra(2, cio_pkg::REG_DRIVE), 8'h81);
        wr_reg(ra(0, cio_pkg::REG_DRIVE), 8'hFF);
        idle(2);
        chk56(pin_fast, {32'h0, 8'h81, 16'h0});
        // Enable readback is the OR of direction and array term
        aoe = 56'h80;
        wr_reg(ra(0, cio_pkg::REG_DIR), 8'h01);
        idle(2);
        rd_reg(ra(0, cio_pkg::REG_OEN), 8'h81);
        aoe = 56'h0;
        wr_reg(ra(0, cio_pkg::REG_DIR), 8'h00);
        wr_reg(ra(0, cio_pkg::REG_DRIVE), 8'h00);
        // Pin levels and input cells on A, held when the strobe drops
        ext_en = 56'hFF;
        ext_val = 56'h6B;
        strobe = 1'b1;
        idle(4);
        rd_reg(ra(0, cio_pkg::REG_DIN), 8'h6B);
        rd_reg(ra(0, cio_pkg::REG_ICELL), 8'h6B);
        strobe = 1'b0;
        idle(3);
        ext_val = 56'h00;
        idle(4);
        rd_reg(ra(0, cio_pkg::REG_ICELL), 8'h6B);
        rd_reg(ra(0, cio_pkg::REG_DIN), 8'h00);
        // Array sees held cells on A[7:4], live pins elsewhere; decode keeps only marked pins
        icl = 24'hF0;
        duse = 56'hFFFF;
        idle(2);
        chk56(arr_in, {48'hFFFF_FFFF_FFFF, 8'h60});
        chk56(dec_in, 56'hFF60);
        icl = 24'h0;
        duse = 56'h0;
        ext_en = 56'h0;
        // Output cells and their load mask
        rd_reg(ra(1, cio_pkg::REG_OMASK), 8'h00);
        wr_reg(ra(0, cio_pkg::REG_OCELL), 8'h00);
        rd_reg(ra(0, cio_pkg::REG_OCELL), 8'h00);
        wr_reg(ra(0, cio_pkg::REG_OMASK), 8'h0F);
        rd_reg(ra(0, cio_pkg::REG_OMASK), 8'h0F);
        wr_reg(ra(0, cio_pkg::REG_OCELL), 8'hFF);
        rd_reg(ra(0, cio_pkg::REG_OCELL), 8'hF0);
        wr_reg(ra(1, cio_pkg::REG_OCELL), 8'h5A);
        rd_reg(ra(1, cio_pkg::REG_OCELL), 8'h5A);
        chk56({40'h0, ocell_out}, 56'h5AF0);
        // Peripheral buffer on F, driven only under a select
        wr_reg(cio_pkg::ADDR_MEMMAP_CFG, 8'h80);
        rd_reg(cio_pkg::ADDR_MEMMAP_CFG, 8'h80);
        bus_wr = 1'b1;
        bus_wdata = 8'h3C;
        idle(3);
        chk56(pin_oe, 56'h0);
        ps1 = 1'b1;
        idle(2);
        chk56(pin_out & pin_oe, {8'h0, 8'h3C, 40'h0});
        ps1 = 1'b0;
        ps0 = 1'b1;
        idle(2);
        chk56(pin_oe, {8'h0, 8'hFF, 40'h0});
        chk8(pf_data, 8'h3C);
        ps0 = 1'b0;
        bus_wr = 1'b0;
        idle(2);
        chk56(pin_oe, 56'h0);
        // Data port wins over the buffer mode
        dpm = 1'b1;
        bus_rd = 1'b1;
        bus_rdata = 8'hC3;
        idle(2);
        chk56(pin_out & pin_oe, {8'h0, 8'hC3, 40'h0});
        bus_rd = 1'b0;
        idle(2);
        chk56(pin_oe, 56'h0);
        dpm = 1'b0;
        // Programming port takes the E data-out pin from host I/O
        wr_reg(ra(4, cio_pkg::REG_DIR), 8'h08);
        idle(2);
        chk56(pin_oe, {16'h0, 8'h08, 32'h0});
        jtag_en = 1'b1;
        idle(2);
        chk56(pin_oe, 56'h0);
        results();
    end
endmodule : cio_port_bank_bench
bind cio_port_bank cio_port_bank_props chk (.*);
